// ===== rtl/slsr_pkg.sv
package slsr_pkg;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index.
  // ----------------------------------------------------------------
  localparam logic [11:0] SLSR_IDX_LANE4_STATUS = 12'h4B4;
  localparam logic [11:0] SLSR_IDX_LANE5_STATUS = 12'h4B5;
  localparam logic [11:0] SLSR_IDX_THRESHOLD = 12'h4C0;
  localparam logic [11:0] SLSR_IDX_CONTROL = 12'h4C1;
  localparam logic [11:0] SLSR_IDX_IRQ_STATUS = 12'h4C2;
  localparam logic [11:0] SLSR_IDX_IRQ_MASK = 12'h4C3;

  // ----------------------------------------------------------------
  // Lane status field positions.
  // ----------------------------------------------------------------
  localparam int SLSR_BIT_DISPARITY = 7;
  localparam int SLSR_BIT_INVALID = 6;
  localparam int SLSR_BIT_UNEXP_CTRL = 5;
  localparam int SLSR_BIT_DESKEW = 4;
  localparam int SLSR_BIT_INIT_ALIGN = 3;
  localparam int SLSR_BIT_CHECKSUM = 2;
  localparam int SLSR_BIT_FRAME_SYNC = 1;
  localparam int SLSR_BIT_CG_SYNC = 0;

  // ----------------------------------------------------------------
  // Control and interrupt field positions.
  // ----------------------------------------------------------------
  localparam int SLSR_BIT_SKIP_ALIGN = 0;
  localparam int SLSR_IRQ_DISPARITY = 0;
  localparam int SLSR_IRQ_INVALID = 1;
  localparam int SLSR_IRQ_UNEXP_CTRL = 2;
  localparam int SLSR_IRQ_LANE5_CG_LOST = 3;
  localparam int SLSR_IRQ_LANE4_CG_LOST = 4;
  localparam int SLSR_IRQ_W = 5;

  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  localparam logic [7:0] SLSR_RST_STATUS = 8'h00;
  localparam logic [7:0] SLSR_RST_THRESHOLD = 8'h00;
  localparam logic [SLSR_IRQ_W-1:0] SLSR_RST_IRQ = 5'h00;
  localparam logic [31:0] SLSR_RST_RDATA = 32'h00000000;

endpackage : slsr_pkg

// ===== rtl/slsr_top.sv
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ns
// Contract
// RL1: Lane5 bit7 set when disparity count >= threshold.
// RL2: Lane5 bit6 set when invalid-symbol count >= threshold.
// RL3: Lane5 bit5 set when unexpected-control count >= threshold.
// RL4: Bit4 shows deskew achieved, zero when failed.
// RL5: Bit3 shows initial alignment achieved or lost.
// RL6: Bit2 shows received configuration checksum correct.
// RL7: Bit1 shows frame sync achieved or lost.
// RL8: Bit0 shows code group sync, always meaningful.
// RL9: Lane4 carries bits 4..0 alike, reset zero.
// RL10: Software ignores bits 4..1 when skipping alignment.
// RL11: Writes to lane status registers are ignored.
module slsr_top
  import slsr_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  input wire logic [7:0] LANE5_DISPARITY_ERR_COUNT,
  input wire logic [7:0] LANE5_INVALID_SYMBOL_COUNT,
  input wire logic [7:0] LANE5_UNEXPECTED_CTRL_COUNT,
  input wire logic LANE5_DESKEW_OK,
  input wire logic LANE5_INIT_ALIGN_OK,
  input wire logic LANE5_CHECKSUM_OK,
  input wire logic LANE5_FRAME_SYNC_OK,
  input wire logic LANE5_CODEGROUP_SYNC_OK,
  input wire logic LANE4_DESKEW_OK,
  input wire logic LANE4_INIT_ALIGN_OK,
  input wire logic LANE4_CHECKSUM_OK,
  input wire logic LANE4_FRAME_SYNC_OK,
  input wire logic LANE4_CODEGROUP_SYNC_OK,
  output logic [7:0] LANE_ERROR_THRESHOLD,
  output logic SKIP_INITIAL_ALIGNMENT,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  logic [7:0] lane5_link_status_q;
  logic [7:0] lane5_link_status_d;
  logic [7:0] lane4_link_status_q;
  logic [7:0] lane4_link_status_d;
  logic [7:0] threshold_q;
  logic skip_align_q;
  logic [SLSR_IRQ_W-1:0] irq_stat_q;
  logic [SLSR_IRQ_W-1:0] irq_stat_d;
  logic [SLSR_IRQ_W-1:0] irq_mask_q;
  logic [SLSR_IRQ_W-1:0] irq_event;
  logic [SLSR_IRQ_W-1:0] irq_clear;
  logic addr_phase;
  logic wr_pend_q;
  logic [11:0] wr_idx_q;
  logic [11:0] addr_idx;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic chk_armed_q;

  // ----------------------------------------------------------------
  // Lane status capture.
  // ----------------------------------------------------------------

  // Flags are recomputed every cycle from the live receiver state, so
  // a count that drops below the threshold clears its flag again.
  always_comb begin
    lane5_link_status_d = SLSR_RST_STATUS;
    lane5_link_status_d[SLSR_BIT_DISPARITY] =
      (LANE5_DISPARITY_ERR_COUNT >= threshold_q); // RL1
    lane5_link_status_d[SLSR_BIT_INVALID] =
      (LANE5_INVALID_SYMBOL_COUNT >= threshold_q); // RL2
    lane5_link_status_d[SLSR_BIT_UNEXP_CTRL] =
      (LANE5_UNEXPECTED_CTRL_COUNT >= threshold_q); // RL3
    lane5_link_status_d[SLSR_BIT_DESKEW] = LANE5_DESKEW_OK; // RL4
    lane5_link_status_d[SLSR_BIT_INIT_ALIGN] = LANE5_INIT_ALIGN_OK; // RL5
    lane5_link_status_d[SLSR_BIT_CHECKSUM] = LANE5_CHECKSUM_OK; // RL6
    lane5_link_status_d[SLSR_BIT_FRAME_SYNC] = LANE5_FRAME_SYNC_OK; // RL7
    lane5_link_status_d[SLSR_BIT_CG_SYNC] = LANE5_CODEGROUP_SYNC_OK; // RL8
  end

  // Lane 4 only reports the sync fields; its upper bits read as zero.
  always_comb begin
    lane4_link_status_d = SLSR_RST_STATUS; // RL9
    lane4_link_status_d[SLSR_BIT_DESKEW] = LANE4_DESKEW_OK; // RL4
    lane4_link_status_d[SLSR_BIT_INIT_ALIGN] = LANE4_INIT_ALIGN_OK; // RL5
    lane4_link_status_d[SLSR_BIT_CHECKSUM] = LANE4_CHECKSUM_OK; // RL6
    lane4_link_status_d[SLSR_BIT_FRAME_SYNC] = LANE4_FRAME_SYNC_OK; // RL7
    lane4_link_status_d[SLSR_BIT_CG_SYNC] = LANE4_CODEGROUP_SYNC_OK; // RL8
  end

  // The status registers have no write path at all, so a bus write can
  // never mask a live error or sync condition.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      lane5_link_status_q <= SLSR_RST_STATUS;
      lane4_link_status_q <= SLSR_RST_STATUS; // RL9
    end else begin
      lane5_link_status_q <= lane5_link_status_d; // RL11
      lane4_link_status_q <= lane4_link_status_d; // RL11
    end
  end

  // ----------------------------------------------------------------
  // Bus slave.
  // ----------------------------------------------------------------

  // The slave never stalls and never reports an error.
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_q;
  assign addr_phase = HSEL && HTRANS[1] && HREADY;
  assign addr_idx = HADDR[13:2];

  // Write address is held over to the data phase, where HWDATA stands.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 12'h000;
    end else begin
      wr_pend_q <= addr_phase && HWRITE;
      if (addr_phase) begin
        wr_idx_q <= addr_idx;
      end
    end
  end

  // Read data is sampled in the address phase; a read that directly
  // follows a write to the same register sees the old value.
  always_comb begin
    case (addr_idx)
      SLSR_IDX_LANE4_STATUS: rdata_d = {24'h000000, lane4_link_status_q};
      SLSR_IDX_LANE5_STATUS: rdata_d = {24'h000000, lane5_link_status_q};
      SLSR_IDX_THRESHOLD: rdata_d = {24'h000000, threshold_q};
      SLSR_IDX_CONTROL: rdata_d = {31'h00000000, skip_align_q};
      SLSR_IDX_IRQ_STATUS: rdata_d = {27'h0000000, irq_stat_q};
      SLSR_IDX_IRQ_MASK: rdata_d = {27'h0000000, irq_mask_q};
      default: rdata_d = SLSR_RST_RDATA;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q <= SLSR_RST_RDATA;
    end else if (addr_phase && !HWRITE) begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers.
  // ----------------------------------------------------------------

  // Threshold and skip bit drive the compare above and the receiver.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      threshold_q <= SLSR_RST_THRESHOLD;
      skip_align_q <= 1'b0;
      irq_mask_q <= SLSR_RST_IRQ;
    end else if (wr_pend_q) begin
      if (wr_idx_q == SLSR_IDX_THRESHOLD) begin
        threshold_q <= HWDATA[7:0];
      end
      if (wr_idx_q == SLSR_IDX_CONTROL) begin
        skip_align_q <= HWDATA[SLSR_BIT_SKIP_ALIGN];
      end
      if (wr_idx_q == SLSR_IDX_IRQ_MASK) begin
        irq_mask_q <= HWDATA[SLSR_IRQ_W-1:0];
      end
    end
  end

  assign LANE_ERROR_THRESHOLD = threshold_q;
  assign SKIP_INITIAL_ALIGNMENT = skip_align_q;

  // ----------------------------------------------------------------
  // Interrupts.
  // ----------------------------------------------------------------

  // Events are the rising edge of each error flag and the loss of
  // code group sync, the one sync bit valid even when skipping.
  always_comb begin
    irq_event = SLSR_RST_IRQ;
    irq_event[SLSR_IRQ_DISPARITY] = lane5_link_status_d[SLSR_BIT_DISPARITY]
      && !lane5_link_status_q[SLSR_BIT_DISPARITY];
    irq_event[SLSR_IRQ_INVALID] = lane5_link_status_d[SLSR_BIT_INVALID]
      && !lane5_link_status_q[SLSR_BIT_INVALID];
    irq_event[SLSR_IRQ_UNEXP_CTRL] = lane5_link_status_d[SLSR_BIT_UNEXP_CTRL]
      && !lane5_link_status_q[SLSR_BIT_UNEXP_CTRL];
    irq_event[SLSR_IRQ_LANE5_CG_LOST] = !lane5_link_status_d[SLSR_BIT_CG_SYNC]
      && lane5_link_status_q[SLSR_BIT_CG_SYNC];
    irq_event[SLSR_IRQ_LANE4_CG_LOST] = !lane4_link_status_d[SLSR_BIT_CG_SYNC]
      && lane4_link_status_q[SLSR_BIT_CG_SYNC];
  end

  // Write-one-to-clear; a new event in the clearing cycle still sets.
  assign irq_clear = (wr_pend_q && wr_idx_q == SLSR_IDX_IRQ_STATUS) ?
    HWDATA[SLSR_IRQ_W-1:0] : SLSR_RST_IRQ;
  assign irq_stat_d = (irq_stat_q & ~irq_clear) | irq_event;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_stat_q <= SLSR_RST_IRQ;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  assign IRQ = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------

  // Checking starts one edge after reset is released. A reset lifted at
  // a clock edge still holds the registers at that edge, so an attempt
  // started there would expect a load that has not happened yet.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      chk_armed_q <= 1'b0;
    end else begin
      chk_armed_q <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!chk_armed_q);

  sequence s_status_write;
    wr_pend_q && (wr_idx_q == SLSR_IDX_LANE5_STATUS
      || wr_idx_q == SLSR_IDX_LANE4_STATUS);
  endsequence

  sequence s_lane5_read;
    addr_phase && !HWRITE && addr_idx == SLSR_IDX_LANE5_STATUS;
  endsequence

  a_disparity_flag: assert property ((LANE5_DISPARITY_ERR_COUNT >= threshold_q) // RL1
    |=> lane5_link_status_q[SLSR_BIT_DISPARITY]) else $error("Disparity flag not set.");

  a_invalid_flag: assert property ((LANE5_INVALID_SYMBOL_COUNT < threshold_q) // RL2
    |=> !lane5_link_status_q[SLSR_BIT_INVALID]) else $error("Invalid flag set below.");

  a_unexp_flag: assert property (##1 lane5_link_status_q[SLSR_BIT_UNEXP_CTRL] // RL3
    == $past(LANE5_UNEXPECTED_CTRL_COUNT >= threshold_q)) else $error("Ctrl flag wrong.");

  a_deskew_bit: assert property ($rose(LANE4_DESKEW_OK) // RL4
    |=> lane4_link_status_q[SLSR_BIT_DESKEW]) else $error("Lane4 deskew not shown.");

  a_align_bit: assert property ($fell(LANE5_INIT_ALIGN_OK) // RL5
    |=> !lane5_link_status_q[SLSR_BIT_INIT_ALIGN]) else $error("Align loss not shown.");

  a_checksum_bit: assert property (LANE5_CHECKSUM_OK [*2] // RL6
    |-> lane5_link_status_q[SLSR_BIT_CHECKSUM]) else $error("Checksum bit wrong.");

  a_frame_sync: assert property (!LANE4_FRAME_SYNC_OK // RL7
    |=> !lane4_link_status_q[SLSR_BIT_FRAME_SYNC]) else $error("Frame sync wrong.");

  a_cg_read: assert property (s_lane5_read // RL8
    |=> HRDATA[SLSR_BIT_CG_SYNC] == $past(lane5_link_status_q[SLSR_BIT_CG_SYNC]))
    else $error("Code group read wrong.");

  a_lane4_upper: assert property (lane4_link_status_q[7:5] == 3'h0) // RL9
    else $error("Lane4 upper bits not zero.");

  a_write_ignored: assert property (s_status_write // RL11
    |=> lane5_link_status_q == $past(lane5_link_status_d)) else $error("Status was written.");

  a_irq_sticky: assert property (irq_event[SLSR_IRQ_LANE5_CG_LOST]
    |=> irq_stat_q[SLSR_IRQ_LANE5_CG_LOST]) else $error("Event lost.");

  a_disparity_low: assert property ((LANE5_DISPARITY_ERR_COUNT < threshold_q) // RL1
    |=> !lane5_link_status_q[SLSR_BIT_DISPARITY]) else $error("Disparity flag set below.");

  a_invalid_high: assert property ((LANE5_INVALID_SYMBOL_COUNT >= threshold_q) // RL2
    |=> lane5_link_status_q[SLSR_BIT_INVALID]) else $error("Invalid flag not set.");

  a_lane5_deskew: assert property (LANE5_DESKEW_OK // RL4
    |=> lane5_link_status_q[SLSR_BIT_DESKEW]) else $error("Lane5 deskew not shown.");

  a_lane4_align: assert property (!LANE4_INIT_ALIGN_OK // RL5
    |=> !lane4_link_status_q[SLSR_BIT_INIT_ALIGN]) else $error("Lane4 align loss not shown.");

  a_lane4_checksum: assert property (##1 lane4_link_status_q[SLSR_BIT_CHECKSUM] // RL6
    == $past(LANE4_CHECKSUM_OK)) else $error("Lane4 checksum bit wrong.");

  a_lane5_frame: assert property (LANE5_FRAME_SYNC_OK // RL7
    |=> lane5_link_status_q[SLSR_BIT_FRAME_SYNC]) else $error("Lane5 frame sync wrong.");

  a_lane4_cg: assert property (##1 lane4_link_status_q[SLSR_BIT_CG_SYNC] // RL8
    == $past(LANE4_CODEGROUP_SYNC_OK)) else $error("Lane4 code group wrong.");

  a_lane4_write: assert property (s_status_write // RL11
    |=> lane4_link_status_q == $past(lane4_link_status_d)) else $error("Lane4 written.");

endmodule // slsr_top

// ===== verification/slsr_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench
  import slsr_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus signals.
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [7:0] cnt [3];
  logic [4:0] ok5 = 5'h00;
  logic [4:0] ok4 = 5'h00;
  logic [7:0] thr_out;
  logic skip_out;
  logic irq;
  logic [7:0] thr = 8'h00;
  logic [31:0] rd_q;
  int err_total = 0;
  int checks_done = 0;

  initial foreach (cnt[i]) cnt[i] = 8'h00;
  // The single slave's ready is the bus ready, so no separate stall source exists.
  always #50 clk = ~clk;

  slsr_top slsr_top_i (.CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp),
    .LANE5_DISPARITY_ERR_COUNT(cnt[0]), .LANE5_INVALID_SYMBOL_COUNT(cnt[1]),
    .LANE5_UNEXPECTED_CTRL_COUNT(cnt[2]), .LANE5_DESKEW_OK(ok5[4]),
    .LANE5_INIT_ALIGN_OK(ok5[3]), .LANE5_CHECKSUM_OK(ok5[2]), .LANE5_FRAME_SYNC_OK(ok5[1]),
    .LANE5_CODEGROUP_SYNC_OK(ok5[0]), .LANE4_DESKEW_OK(ok4[4]), .LANE4_INIT_ALIGN_OK(ok4[3]),
    .LANE4_CHECKSUM_OK(ok4[2]), .LANE4_FRAME_SYNC_OK(ok4[1]),
    .LANE4_CODEGROUP_SYNC_OK(ok4[0]), .LANE_ERROR_THRESHOLD(thr_out),
    .SKIP_INITIAL_ALIGNMENT(skip_out), .IRQ(irq));

  // ----------------------------------------------------------------
  // Bus tasks; each holds a phase until ready is seen at an edge.
  // ----------------------------------------------------------------
  task automatic xfer(input logic [11:0] idx, input logic is_wr, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= is_wr;
    hsize <= 3'h2;
    haddr <= {18'h0, idx, 2'b00};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_q = hrdata;
    `CHK(hresp, 1'b0)
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    xfer(idx, 1'b1, d);
  endtask

  task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
    xfer(idx, 1'b0, 32'h0);
    `CHK(rd_q, exp)
  endtask

  // Live inputs change on an edge and get one more edge to reach the registers.
  task automatic drive(input int k, input logic [7:0] v);
    @(posedge clk);
    cnt[k] <= v;
    @(posedge clk);
  endtask

  function automatic logic [31:0] exp5();
    return {24'h0, cnt[0] >= thr, cnt[1] >= thr, cnt[2] >= thr, ok5};
  endfunction

  task automatic irq_is(input logic v);
    @(negedge clk);
    `CHK(irq, v)
  endtask

  task automatic conclude();
    $display("Checks %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    `CHK({hrdata, hreadyout, thr_out, skip_out, irq}, {32'h0, 1'b1, 8'h00, 1'b0, 1'b0})
    rstn <= 1'b1;
    rd(SLSR_IDX_LANE4_STATUS, 32'h0);
    rd(SLSR_IDX_LANE5_STATUS, 32'hE0);
    rd(SLSR_IDX_THRESHOLD, 32'h0);
    rd(12'h7F0, 32'h0);
    // Threshold zero makes every flag rise at start-up, so clear that first.
    thr = 8'h10;
    wr(SLSR_IDX_THRESHOLD, {24'h0, thr});
    // The register loads at the edge that ends the task, so look half a cycle on.
    @(negedge clk);
    `CHK(thr_out, thr)
    wr(SLSR_IDX_IRQ_STATUS, 32'h1F);
    rd(SLSR_IDX_IRQ_STATUS, 32'h0);
    // Each counter just below, at and far above the threshold.
    for (int k = 0; k < 3; k++) begin
      drive(k, 8'h0F);
      rd(SLSR_IDX_LANE5_STATUS, exp5());
      drive(k, 8'h10);
      rd(SLSR_IDX_LANE5_STATUS, exp5());
      drive(k, 8'hFF);
      rd(SLSR_IDX_LANE5_STATUS, exp5());
      drive(k, 8'h00);
    end
    rd(SLSR_IDX_IRQ_STATUS, 32'h07);
    irq_is(1'b0);
    wr(SLSR_IDX_IRQ_MASK, 32'h01);
    irq_is(1'b1);
    wr(SLSR_IDX_IRQ_STATUS, 32'h01);
    irq_is(1'b0);
    rd(SLSR_IDX_IRQ_STATUS, 32'h06);
    // Walk one achieved level across both lanes in opposite directions.
    for (int b = 0; b < 5; b++) begin
      @(posedge clk);
      ok5 <= 5'h01 << b;
      ok4 <= 5'h10 >> b;
      @(posedge clk);
      rd(SLSR_IDX_LANE5_STATUS, exp5());
      rd(SLSR_IDX_LANE4_STATUS, {27'h0, ok4});
    end
    @(posedge clk);
    ok4 <= 5'h00;
    // Writes to lane status must not disturb the live view.
    wr(SLSR_IDX_LANE5_STATUS, 32'hFFFFFFFF);
    rd(SLSR_IDX_LANE5_STATUS, exp5());
    wr(SLSR_IDX_LANE4_STATUS, 32'hFFFFFFFF);
    rd(SLSR_IDX_LANE4_STATUS, 32'h0);
    rd(SLSR_IDX_IRQ_STATUS, 32'h1E);
    wr(SLSR_IDX_IRQ_MASK, 32'h18);
    rd(SLSR_IDX_IRQ_MASK, 32'h18);
    irq_is(1'b1);
    wr(SLSR_IDX_IRQ_STATUS, 32'h1F);
    irq_is(1'b0);
    // The skip setting only tells software to ignore bits; they stay live.
    wr(SLSR_IDX_CONTROL, 32'h1);
    @(negedge clk);
    `CHK(skip_out, 1'b1)
    rd(SLSR_IDX_CONTROL, 32'h1);
    rd(SLSR_IDX_LANE5_STATUS, exp5());
    // A reset in mid-run brings every register back to its reset value.
    @(posedge clk);
    rstn <= 1'b0;
    @(negedge clk);
    `CHK({hrdata, thr_out, skip_out, irq}, {32'h0, 8'h00, 1'b0, 1'b0})
    @(posedge clk);
    rstn <= 1'b1;
    thr = 8'h00;
    rd(SLSR_IDX_THRESHOLD, 32'h0);
    rd(SLSR_IDX_CONTROL, 32'h0);
    rd(SLSR_IDX_IRQ_MASK, 32'h0);
    rd(SLSR_IDX_LANE5_STATUS, exp5());
    rd(SLSR_IDX_IRQ_STATUS, 32'h07);
    conclude();
  end

  // A hung handshake is cut short well after the expected run length.
  initial begin
    #(100 * 3000);
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    conclude();
  end
endmodule // testbench
